// File: socket_regs_pkg.sv
// Operation
// - identification bits 7-6 are read-only, fixed at binary 10
// - identification bits 5-4 are reserved, but software can write and read them
// - identification bits 3-0 hold a writable revision, loaded with a fixed code at reset
// - each socket has its own copy: A at index 00h, B at 40h
// - status register is also readable at socket memory base plus 801h
// - status register is read-only, bit 7 reads 0, writes change nothing
// - status bit 6 reads 1 while socket supply is switched on
// - status bit 5 shows the card ready line level
// - status bit 4 follows the card write-protect input
// - status bit 3 is second card-detect pin inverted
// - status bit 2 is first card-detect pin inverted
// - memory card: bit 1 is second battery pin, bit 0 first
// - I/O card: bit 1 is audio pin, bit 0 status-change pin
// - after reset status bits 7-6 read 0, bits 5-0 follow pins
// - a window protect bit blocks writes to that whole memory window
// - supply field bits 4-3 of power control: 00 off, 10 5V, 11 3V
package socket_regs_pkg;

    localparam int unsigned NUM_SOCKETS_DEF = 2;
    localparam int unsigned NUM_WINDOWS_DEF = 5;

    localparam int unsigned IDX_W           = 7;
    localparam int unsigned MEM_ADDR_W      = 12;
    localparam int unsigned DATA_W          = 8;

    // index layout: bit 6 picks the socket, bits 5-0 the register
    localparam int unsigned SOCKET_SEL_BIT  = 6;
    localparam logic [5:0]  IDX_ID          = 6'h00;
    localparam logic [5:0]  IDX_STATUS      = 6'h01;
    localparam logic [5:0]  IDX_POWER       = 6'h02;
    localparam logic [5:0]  IDX_GENCTL      = 6'h03;
    localparam logic [MEM_ADDR_W-1:0] MEM_STATUS_ADDR = 12'h801;

    // identification fields
    localparam logic [1:0]  ID_TYPE_VALUE   = 2'h2;
    localparam int unsigned ID_TYPE_LSB     = 6;
    localparam int unsigned ID_RSVD_LSB     = 4;
    localparam int unsigned ID_REV_LSB      = 0;
    localparam logic [1:0]  ID_RSVD_RESET   = 2'h0;

    // status bits
    localparam int unsigned ST_ZERO_BIT     = 7;
    localparam int unsigned ST_POWER_BIT    = 6;
    localparam int unsigned ST_READY_BIT    = 5;
    localparam int unsigned ST_WP_BIT       = 4;
    localparam int unsigned ST_CD_B_BIT     = 3;
    localparam int unsigned ST_CD_A_BIT     = 2;
    localparam int unsigned ST_BVD_B_BIT    = 1;
    localparam int unsigned ST_BVD_A_BIT    = 0;

    // power control and general control fields kept here
    localparam int unsigned PWR_SUPPLY_LSB  = 3;
    localparam logic [1:0]  SUPPLY_OFF      = 2'h0;
    localparam logic [1:0]  SUPPLY_5V       = 2'h2;
    localparam logic [1:0]  SUPPLY_3V       = 2'h3;
    localparam int unsigned GEN_KIND_BIT    = 5;
    localparam logic        KIND_MEMORY     = 1'h0;

    // pin order inside each socket's synchronised group
    localparam int unsigned PINS_PER_SOCKET = 8;
    localparam int unsigned PIN_READY       = 0;
    localparam int unsigned PIN_WP          = 1;
    localparam int unsigned PIN_CD_A        = 2;
    localparam int unsigned PIN_CD_B        = 3;
    localparam int unsigned PIN_BVD_A       = 4;
    localparam int unsigned PIN_BVD_B       = 5;
    localparam int unsigned PIN_AUDIO       = 6;
    localparam int unsigned PIN_CHANGE      = 7;

    localparam logic [DATA_W-1:0] UNMAPPED_DATA = 8'h00;

endpackage

// File: socket_pin_sync.sv
`timescale 1ns/1ps
module socket_pin_sync #(
    parameter int unsigned WIDTH = 16
) (
    input  wire logic             ref_clk_i,
    input  wire logic             rstn_i,
    input  wire logic [WIDTH-1:0] pins_i,
    output logic      [WIDTH-1:0] pins_o
);
    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } sync_s;

    sync_s st_q;
    sync_s st_d;

    if (WIDTH < 1) begin : g_width_check
        $error("socket_pin_sync: WIDTH must be at least 1");
    end

    always_comb begin
        st_d        = st_q;
        st_d.stage1 = pins_i;
        st_d.stage2 = st_q.stage1;
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign pins_o = st_q.stage2;
endmodule // socket_pin_sync

// File: socket_id_status_regs.sv
`timescale 1ns/1ps
module socket_id_status_regs
    import socket_regs_pkg::*;
#(
    parameter int unsigned NUM_SOCKETS = socket_regs_pkg::NUM_SOCKETS_DEF,
    parameter int unsigned NUM_WINDOWS = socket_regs_pkg::NUM_WINDOWS_DEF,
    // arbitrary value, not a real part's revision
    parameter logic [3:0]  REV_RESET   = 4'h1
) (
    input  wire logic                                      ref_clk_i,
    input  wire logic                                      rstn_i,
    input  wire logic [socket_regs_pkg::IDX_W-1:0]         reg_addr_i,
    input  wire logic                                      reg_wr_i,
    input  wire logic                                      reg_rd_i,
    input  wire logic [socket_regs_pkg::DATA_W-1:0]        reg_wdata_i,
    input  wire logic                                      mem_rd_i,
    input  wire logic                                      mem_wr_i,
    input  wire logic [socket_regs_pkg::MEM_ADDR_W-1:0]    mem_addr_i,
    input  wire logic                                      mem_socket_i,
    input  wire logic [NUM_SOCKETS-1:0]                    card_ready_i,
    input  wire logic [NUM_SOCKETS-1:0]                    card_write_protect_i,
    input  wire logic [NUM_SOCKETS-1:0]                    card_detect_pin_a_i,
    input  wire logic [NUM_SOCKETS-1:0]                    card_detect_pin_b_i,
    input  wire logic [NUM_SOCKETS-1:0]                    battery_detect_pin_a_i,
    input  wire logic [NUM_SOCKETS-1:0]                    battery_detect_pin_b_i,
    input  wire logic [NUM_SOCKETS-1:0]                    card_audio_pin_i,
    input  wire logic [NUM_SOCKETS-1:0]                    card_status_change_pin_i,
    input  wire logic [NUM_SOCKETS*NUM_WINDOWS-1:0]        window_protect_i,
    output logic      [socket_regs_pkg::DATA_W-1:0]        rd_data_o,
    output logic                                           rd_valid_o,
    output logic      [NUM_SOCKETS-1:0]                    socket_power_on_o,
    output logic      [NUM_SOCKETS*NUM_WINDOWS-1:0]        window_write_block_o
);
    import socket_regs_pkg::*;

    localparam int unsigned SYNC_W = NUM_SOCKETS * PINS_PER_SOCKET;

    typedef struct packed {
        logic [NUM_SOCKETS-1:0][1:0]       id_rsvd;
        logic [NUM_SOCKETS-1:0][3:0]       revision;
        logic [NUM_SOCKETS-1:0][1:0]       supply;
        logic [NUM_SOCKETS-1:0]            kind;
        logic [NUM_SOCKETS-1:0]            power_on;
        logic [NUM_SOCKETS*NUM_WINDOWS-1:0] wr_block;
        logic [DATA_W-1:0]                 rd_data;
        logic                              rd_valid;
    } regs_s;

    regs_s st_q;
    regs_s st_d;

    logic [SYNC_W-1:0]              raw_pins;
    logic [SYNC_W-1:0]              sync_pins;
    logic [7:0]                     status_byte [NUM_SOCKETS];
    logic [7:0]                     id_byte     [NUM_SOCKETS];

    // index decode uses one address bit for the socket
    if (NUM_SOCKETS != 2) begin : g_sockets_check
        $error("socket_id_status_regs: index decode serves exactly two sockets");
    end
    if (NUM_WINDOWS < 1) begin : g_windows_check
        $error("socket_id_status_regs: NUM_WINDOWS must be at least 1");
    end

    for (genvar s = 0; s < NUM_SOCKETS; s++) begin : g_sock
        assign raw_pins[s*PINS_PER_SOCKET+PIN_READY]  = card_ready_i[s];
        assign raw_pins[s*PINS_PER_SOCKET+PIN_WP]     = card_write_protect_i[s];
        assign raw_pins[s*PINS_PER_SOCKET+PIN_CD_A]   = card_detect_pin_a_i[s];
        assign raw_pins[s*PINS_PER_SOCKET+PIN_CD_B]   = card_detect_pin_b_i[s];
        assign raw_pins[s*PINS_PER_SOCKET+PIN_BVD_A]  = battery_detect_pin_a_i[s];
        assign raw_pins[s*PINS_PER_SOCKET+PIN_BVD_B]  = battery_detect_pin_b_i[s];
        assign raw_pins[s*PINS_PER_SOCKET+PIN_AUDIO]  = card_audio_pin_i[s];
        assign raw_pins[s*PINS_PER_SOCKET+PIN_CHANGE] = card_status_change_pin_i[s];

        always_comb begin
            id_byte[s]                                 = '0;
            id_byte[s][ID_TYPE_LSB +: 2]               = ID_TYPE_VALUE;
            id_byte[s][ID_RSVD_LSB +: 2]               = st_q.id_rsvd[s];
            id_byte[s][ID_REV_LSB +: 4]                = st_q.revision[s];

            status_byte[s]                             = '0;
            status_byte[s][ST_ZERO_BIT]                = 1'b0;
            status_byte[s][ST_POWER_BIT]               = st_q.power_on[s];
            status_byte[s][ST_READY_BIT]               =
                sync_pins[s*PINS_PER_SOCKET+PIN_READY];
            status_byte[s][ST_WP_BIT]                  =
                sync_pins[s*PINS_PER_SOCKET+PIN_WP];
            status_byte[s][ST_CD_B_BIT]                =
                ~sync_pins[s*PINS_PER_SOCKET+PIN_CD_B];
            status_byte[s][ST_CD_A_BIT]                =
                ~sync_pins[s*PINS_PER_SOCKET+PIN_CD_A];
            if (st_q.kind[s] == KIND_MEMORY) begin
                status_byte[s][ST_BVD_B_BIT] = sync_pins[s*PINS_PER_SOCKET+PIN_BVD_B];
                status_byte[s][ST_BVD_A_BIT] = sync_pins[s*PINS_PER_SOCKET+PIN_BVD_A];
            end else begin
                status_byte[s][ST_BVD_B_BIT] = sync_pins[s*PINS_PER_SOCKET+PIN_AUDIO];
                status_byte[s][ST_BVD_A_BIT] = sync_pins[s*PINS_PER_SOCKET+PIN_CHANGE];
            end
        end
    end

    socket_pin_sync #(
        .WIDTH (SYNC_W)
    ) u_sync (
        .ref_clk_i (ref_clk_i),
        .rstn_i    (rstn_i),
        .pins_i    (raw_pins),
        .pins_o    (sync_pins)
    );

    always_comb begin
        logic       sock;
        logic [5:0] reg_idx;
        logic [7:0] pwr_byte;
        logic [7:0] gen_byte;
        sock     = reg_addr_i[SOCKET_SEL_BIT];
        reg_idx  = reg_addr_i[5:0];
        pwr_byte = '0;
        gen_byte = '0;
        st_d          = st_q;
        st_d.rd_valid = 1'b0;

        if (reg_wr_i) begin
            case (reg_idx)
                IDX_ID: begin
                    st_d.id_rsvd[sock]  = reg_wdata_i[ID_RSVD_LSB +: 2];
                    st_d.revision[sock] = reg_wdata_i[ID_REV_LSB +: 4];
                end
                IDX_POWER: begin
                    st_d.supply[sock] = reg_wdata_i[PWR_SUPPLY_LSB +: 2];
                end
                IDX_GENCTL: begin
                    st_d.kind[sock] = reg_wdata_i[GEN_KIND_BIT];
                end
                default: begin
                    // status and unmapped indexes ignore writes
                end
            endcase
        end

        if (reg_rd_i) begin
            pwr_byte[PWR_SUPPLY_LSB +: 2] = st_q.supply[sock];
            gen_byte[GEN_KIND_BIT]        = st_q.kind[sock];
            st_d.rd_valid                 = 1'b1;
            case (reg_idx)
                IDX_ID:     st_d.rd_data = id_byte[sock];
                IDX_STATUS: st_d.rd_data = status_byte[sock];
                IDX_POWER:  st_d.rd_data = pwr_byte;
                IDX_GENCTL: st_d.rd_data = gen_byte;
                default:    st_d.rd_data = UNMAPPED_DATA;
            endcase
        end else if (mem_rd_i) begin
            st_d.rd_valid = 1'b1;
            if (mem_addr_i == MEM_STATUS_ADDR) begin
                st_d.rd_data = status_byte[mem_socket_i];
            end else begin
                st_d.rd_data = UNMAPPED_DATA;
            end
        end
        // mem_wr_i to the status address has no effect: read-only

        for (int s = 0; s < NUM_SOCKETS; s++) begin
            st_d.power_on[s] = (st_q.supply[s] == SUPPLY_5V) ||
                               (st_q.supply[s] == SUPPLY_3V);
        end
        st_d.wr_block = window_protect_i;
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_q          <= '0;
            st_q.revision <= {NUM_SOCKETS{REV_RESET}};
            st_q.id_rsvd  <= {NUM_SOCKETS{ID_RSVD_RESET}};
            st_q.supply   <= {NUM_SOCKETS{SUPPLY_OFF}};
            st_q.kind     <= {NUM_SOCKETS{KIND_MEMORY}};
        end else begin
            st_q <= st_d;
        end
    end

    assign rd_data_o            = st_q.rd_data;
    assign rd_valid_o           = st_q.rd_valid;
    assign socket_power_on_o    = st_q.power_on;
    assign window_write_block_o = st_q.wr_block;
endmodule // socket_id_status_regs

// File: socket_regs_props.sv
`timescale 1ns/1ps
module socket_regs_props
    import socket_regs_pkg::*;
#(
    parameter int unsigned NUM_SOCKETS = 2,
    parameter int unsigned NUM_WINDOWS = 5
) (
    input wire logic                             ref_clk_i,
    input wire logic                             rstn_i,
    input wire logic [IDX_W-1:0]                 reg_addr_i,
    input wire logic                             reg_rd_i,
    input wire logic                             mem_rd_i,
    input wire logic [MEM_ADDR_W-1:0]            mem_addr_i,
    input wire logic [NUM_SOCKETS-1:0]           card_ready_i,
    input wire logic [NUM_SOCKETS-1:0]           card_write_protect_i,
    input wire logic [NUM_SOCKETS-1:0]           card_detect_pin_a_i,
    input wire logic [NUM_SOCKETS-1:0]           card_detect_pin_b_i,
    input wire logic [NUM_SOCKETS*NUM_WINDOWS-1:0] window_protect_i,
    input wire logic [DATA_W-1:0]                rd_data_o,
    input wire logic                             rd_valid_o,
    input wire logic [NUM_SOCKETS-1:0]           socket_power_on_o,
    input wire logic [NUM_SOCKETS*NUM_WINDOWS-1:0] window_write_block_o
);
    logic [1:0]               up_q;
    logic [4:0]               snap_q;
    logic [4*NUM_SOCKETS-1:0] p1_q;
    logic [4*NUM_SOCKETS-1:0] p2_q;
    logic [4*NUM_SOCKETS-1:0] pins_w;
    logic                     steady_w;
    logic                     st_rd_w;
    assign pins_w = {card_ready_i, card_write_protect_i, card_detect_pin_a_i, card_detect_pin_b_i};
    assign st_rd_w = reg_rd_i && reg_addr_i[5:0] == IDX_STATUS;
    // pins held over the whole synchroniser depth
    assign steady_w = up_q == 2'h3 && st_rd_w && pins_w == p1_q && p1_q == p2_q;
    always_ff @(posedge ref_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            up_q <= 2'h0;
        end else if (up_q != 2'h3) begin
            up_q <= up_q + 2'h1;
        end
    end
    always_ff @(posedge ref_clk_i) begin
        p1_q <= pins_w;
        p2_q <= p1_q;
        snap_q <= {socket_power_on_o[reg_addr_i[6]], card_detect_pin_b_i[reg_addr_i[6]],
                   card_detect_pin_a_i[reg_addr_i[6]], card_write_protect_i[reg_addr_i[6]],
                   card_ready_i[reg_addr_i[6]]};
    end
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rstn_i);
    read_answer_a: assert property (
        (reg_rd_i || mem_rd_i) |=> rd_valid_o) else $error("read not answered");
    no_spurious_a: assert property (
        rd_valid_o |-> $past(reg_rd_i) || $past(mem_rd_i)) else $error("valid without read");
    id_type_a: assert property (
        reg_rd_i && reg_addr_i[5:0] == IDX_ID |=> rd_data_o[7:6] == ID_TYPE_VALUE)
        else $error("interface type wrong");
    status_top_a: assert property (
        st_rd_w |=> !rd_data_o[ST_ZERO_BIT]) else $error("status bit 7 set");
    mem_other_a: assert property (
        mem_rd_i && !reg_rd_i && mem_addr_i != MEM_STATUS_ADDR |=> rd_data_o == UNMAPPED_DATA)
        else $error("memory read of other offset not zero");
    power_bit_a: assert property (
        st_rd_w |=> rd_data_o[ST_POWER_BIT] == snap_q[4]) else $error("power bit wrong");
    ready_line_a: assert property (
        steady_w |=> rd_data_o[ST_READY_BIT] == snap_q[0]) else $error("ready bit wrong");
    protect_pin_a: assert property (
        steady_w |=> rd_data_o[ST_WP_BIT] == snap_q[1]) else $error("protect bit wrong");
    detect_b_a: assert property (
        steady_w |=> rd_data_o[ST_CD_B_BIT] == !snap_q[3]) else $error("detect b wrong");
    detect_a_a: assert property (
        steady_w |=> rd_data_o[ST_CD_A_BIT] == !snap_q[2]) else $error("detect a wrong");
    window_block_a: assert property (
        up_q != 2'h0 |-> window_write_block_o == $past(window_protect_i))
        else $error("window block not following protect");
endmodule // socket_regs_props

// File: card_pin_model.sv
`timescale 1ns/1ps
module card_pin_model (
    input  wire logic [1:0][7:0] ctl_i,
    output logic      [1:0] ready_o,
    output logic      [1:0] wp_o,
    output logic      [1:0] cda_o,
    output logic      [1:0] cdb_o,
    output logic      [1:0] bva_o,
    output logic      [1:0] bvb_o,
    output logic      [1:0] aud_o,
    output logic      [1:0] sts_o
);
    // ctl: 0 ready, 1 protect, 2-3 seated contacts, 4-5 battery, 6 audio, 7 status change
    // empty socket: every card line floats to its pull-up
    always_comb begin
        for (int s = 0; s < 2; s++) begin
            cda_o[s] = !ctl_i[s][2];
            cdb_o[s] = !ctl_i[s][3];
            ready_o[s] = ctl_i[s][0] | ~|ctl_i[s][3:2];
            wp_o[s] = ctl_i[s][1] | ~|ctl_i[s][3:2];
            bva_o[s] = ctl_i[s][4] | ~|ctl_i[s][3:2];
            bvb_o[s] = ctl_i[s][5] | ~|ctl_i[s][3:2];
            aud_o[s] = ctl_i[s][6] | ~|ctl_i[s][3:2];
            sts_o[s] = ctl_i[s][7] | ~|ctl_i[s][3:2];
        end
    end
endmodule // card_pin_model

// File: socket_id_status_regs_bench.sv
`timescale 1ns/1ps
module socket_id_status_regs_bench;
    import socket_regs_pkg::*;
    localparam logic [3:0] REV = 4'h1;
    logic       ref_clk_i = 1'b0, rstn_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
    logic       mem_rd_i = 1'b0, mem_wr_i = 1'b0, mem_socket_i = 1'b0, rd_valid_o;
    logic [6:0] reg_addr_i = 7'h00;
    logic [7:0] reg_wdata_i = 8'h00, rd_data_o;
    logic [11:0] mem_addr_i = 12'h000;
    logic [9:0] window_protect_i = 10'h000, wwb;
    logic [1:0][7:0] ctl = '0;
    logic [1:0] rdy, wp, cda, cdb, bva, bvb, aud, sts, pwr, pe = 2'h0;
    int         err_total = 0, checks = 0, cyc = 0;
    card_pin_model card (.ctl_i(ctl), .ready_o(rdy), .wp_o(wp), .cda_o(cda), .cdb_o(cdb),
        .bva_o(bva), .bvb_o(bvb), .aud_o(aud), .sts_o(sts));
    socket_id_status_regs #(.REV_RESET(REV)) dut (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
        .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_wdata_i(reg_wdata_i), .mem_rd_i(mem_rd_i), .mem_wr_i(mem_wr_i),
        .mem_addr_i(mem_addr_i), .mem_socket_i(mem_socket_i), .card_ready_i(rdy),
        .card_write_protect_i(wp), .card_detect_pin_a_i(cda), .card_detect_pin_b_i(cdb),
        .battery_detect_pin_a_i(bva), .battery_detect_pin_b_i(bvb), .card_audio_pin_i(aud),
        .card_status_change_pin_i(sts), .window_protect_i(window_protect_i),
        .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o), .socket_power_on_o(pwr),
        .window_write_block_o(wwb));
    initial begin
        forever #20 ref_clk_i = ~ref_clk_i;
    end
    task automatic complete_run;
        $display("checks=%0d err_total=%0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic cmp(input logic [9:0] seen, input logic [9:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(negedge ref_clk_i);
        reg_addr_i = a;
        reg_wdata_i = d;
        reg_wr_i = 1'b1;
        @(negedge ref_clk_i);
        reg_wr_i = 1'b0;
    endtask
    // index read when m is 0, memory-space read of offset o otherwise
    task automatic rd(input logic m, input logic [6:0] a, input logic [11:0] o,
                      input logic [7:0] e);
        @(negedge ref_clk_i);
        reg_addr_i = a;
        mem_addr_i = o;
        mem_socket_i = a[6];
        reg_rd_i = !m;
        mem_rd_i = m;
        @(negedge ref_clk_i);
        reg_rd_i = 1'b0;
        mem_rd_i = 1'b0;
        cmp({9'h0, rd_valid_o}, 10'h001);
        cmp({2'h0, rd_data_o}, {2'h0, e});
    endtask
    function automatic logic [7:0] st(input int s, input logic kind);
        st = {1'b0, pe[s], rdy[s], wp[s], !cdb[s], !cda[s],
              kind ? {aud[s], sts[s]} : {bvb[s], bva[s]}};
    endfunction
    always @(posedge ref_clk_i) begin
        cyc++;
        if (cyc == 5000) begin
            err_total++;
            complete_run();
        end
    end
    initial begin
        ctl[0] = 8'h0F;
        repeat (6) @(negedge ref_clk_i);
        rstn_i = 1'b1;
        repeat (3) @(negedge ref_clk_i);
        rd(1'b0, 7'h00, 12'h000, {2'h2, 2'h0, REV});
        rd(1'b0, 7'h01, 12'h000, st(0, 1'b0));
        rd(1'b0, 7'h41, 12'h000, st(1, 1'b0));
        wr(7'h00, 8'h35);
        rd(1'b0, 7'h00, 12'h000, 8'hB5);
        rd(1'b0, 7'h40, 12'h000, {2'h2, 2'h0, REV});
        wr(7'h01, 8'hFF);
        rd(1'b0, 7'h01, 12'h000, st(0, 1'b0));
        rd(1'b0, 7'h10, 12'h000, 8'h00);
        for (int v = 0; v < 4; v++) begin
            wr(7'h42, 8'(v << 3));
            pe[1] = v[1];
            rd(1'b0, 7'h41, 12'h000, st(1, 1'b0));
            cmp({8'h0, pwr}, {8'h0, pe});
        end
        rd(1'b0, 7'h42, 12'h000, 8'h18);
        for (int k = 0; k < 32; k++) begin
            wr({k[0], 6'h03}, {2'h0, k[4], 5'h00});
            ctl[k[0]] = 8'(k * 8'h35);
            repeat (3) @(negedge ref_clk_i);
            rd(1'b0, {k[0], 6'h01}, 12'h000, st(k[0], k[4]));
        end
        rd(1'b0, 7'h43, 12'h000, 8'h20);
        mem_wr_i = 1'b1;
        rd(1'b1, 7'h40, 12'h801, st(1, 1'b1));
        mem_wr_i = 1'b0;
        rd(1'b1, 7'h00, 12'h800, 8'h00);
        window_protect_i = 10'h2A5;
        repeat (2) @(negedge ref_clk_i);
        cmp(wwb, 10'h2A5);
        complete_run();
    end
endmodule // socket_id_status_regs_bench
bind socket_id_status_regs socket_regs_props #(
    .NUM_SOCKETS (NUM_SOCKETS),
    .NUM_WINDOWS (NUM_WINDOWS)
) props (
    .ref_clk_i            (ref_clk_i),
    .rstn_i               (rstn_i),
    .reg_addr_i           (reg_addr_i),
    .reg_rd_i             (reg_rd_i),
    .mem_rd_i             (mem_rd_i),
    .mem_addr_i           (mem_addr_i),
    .card_ready_i         (card_ready_i),
    .card_write_protect_i (card_write_protect_i),
    .card_detect_pin_a_i  (card_detect_pin_a_i),
    .card_detect_pin_b_i  (card_detect_pin_b_i),
    .window_protect_i     (window_protect_i),
    .rd_data_o            (rd_data_o),
    .rd_valid_o           (rd_valid_o),
    .socket_power_on_o    (socket_power_on_o),
    .window_write_block_o (window_write_block_o)
);
